// ==== fifo_ctl_consts.svh ====
`ifndef FIFO_CTL_CONSTS_SVH
`define FIFO_CTL_CONSTS_SVH

// Data path and offset register geometry
`define FIFO_DATA_WIDTH     18
`define FIFO_DEPTH          8
`define OFFSET_WIDTH        12
`define OFFSET_FIELD_LSB    0
`define OFFSET_FIELD_MSB    11

// Offset register reset values (both thresholds)
`define EMPTY_OFFSET_RESET  12'h01F
`define FULL_OFFSET_RESET   12'h01F

// Fall-through: the first word moves out on the third read edge after the write
`define FALL_THROUGH_EDGES  2'h3

// Data output register reset value
`define DATA_OUT_RESET      18'h00000

`endif

// ==== fifo_ctl_pkg.sv ====
`default_nettype none

package fifo_ctl_pkg;

	typedef enum logic {
		mode_standard,
		mode_fall_through
	} timing_mode_e;

	// Standard unless the read-expansion pin is low and the write-expansion pin high
	function automatic timing_mode_e decode_mode(input logic rxi_n, input logic wxi_n);
		return (!rxi_n && wxi_n) ? mode_fall_through : mode_standard;
	endfunction : decode_mode

endpackage : fifo_ctl_pkg

`default_nettype wire

// ==== word_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none

module word_fifo #(
	parameter int WIDTH = 18,
	parameter int DEPTH = 8,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic      [CW-1:0]    count
);

	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr;
	logic [AW-1:0]    rd_ptr;
	logic             push;
	logic             pop;

	function automatic logic [AW-1:0] bump(input logic [AW-1:0] ptr);
		return (ptr == AW'(DEPTH - 1)) ? '0 : AW'(ptr + 1'b1);
	endfunction : bump

	assign in_ready  = (count != CW'(DEPTH));
	assign out_valid = (count != '0);
	assign out_data  = mem[rd_ptr];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem[wr_ptr] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= bump(wr_ptr);
			end
			if (pop) begin
				rd_ptr <= bump(rd_ptr);
			end
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			count <= '0;
		end else if (push && !pop) begin
			count <= CW'(count + 1'b1);
		end else if (pop && !push) begin
			count <= CW'(count - 1'b1);
		end
	end

endmodule : word_fifo

`default_nettype wire

// ==== offset_bank.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_consts.svh"

module offset_bank #(
	parameter int OW = `OFFSET_WIDTH
) (
	input  wire logic          clock,
	input  wire logic          rst_n,
	input  wire logic          wr_en,
	input  wire logic [OW-1:0] wr_data,
	input  wire logic          rd_en,
	output logic      [OW-1:0] rd_data,
	output logic      [OW-1:0] empty_threshold,
	output logic      [OW-1:0] full_threshold
);

	// Separate pointers: low selects the empty threshold, high the full one
	logic wr_sel;
	logic rd_sel;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			empty_threshold <= `EMPTY_OFFSET_RESET;
			full_threshold  <= `FULL_OFFSET_RESET;
			wr_sel          <= 1'b0;
		end else if (wr_en) begin
			if (wr_sel) begin
				full_threshold <= wr_data;
			end else begin
				empty_threshold <= wr_data;
			end
			wr_sel <= !wr_sel;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rd_sel <= 1'b0;
		end else if (rd_en) begin
			rd_sel <= !rd_sel;
		end
	end

	assign rd_data = rd_sel ? full_threshold : empty_threshold;

	// Pointer survives a pause in loading, so writes resume at the next register
	chk_offset_sequence: assert property (@(posedge clock) disable iff (!rst_n)
		wr_en && !wr_sel ##1 !wr_en [*1] ##1 wr_en |=> full_threshold == $past(wr_data))
		else $error("offset write did not continue with the full threshold");

endmodule : offset_bank

`default_nettype wire

// ==== fifo_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_consts.svh"

module fifo_ctl
	import fifo_ctl_pkg::*;
#(
	parameter int DW    = `FIFO_DATA_WIDTH,
	parameter int DEPTH = `FIFO_DEPTH
) (
	input  wire logic                       clock,
	input  wire logic                       rst_n,
	input  wire logic [DW-1:0]              data_in,
	input  wire logic                       write_en_n,
	input  wire logic                       read_en_n,
	input  wire logic                       load_offset_n,
	input  wire logic                       output_en_n,
	input  wire logic                       first_load_n,
	input  wire logic                       read_expansion_in_n,
	input  wire logic                       write_expansion_in_n,
	output logic      [DW-1:0]              data_out,
	output logic                            data_out_oe,
	output logic                            full_flag_n,
	output logic                            empty_flag_n,
	output logic                            half_full_n,
	output logic                            almost_full_n,
	output logic                            almost_empty_n,
	output fifo_ctl_pkg::timing_mode_e      timing_mode
);

	import fifo_ctl_pkg::*;

	localparam int CW = $clog2(DEPTH + 1);
	localparam int OW = `OFFSET_WIDTH;

	timing_mode_e   mode_q;
	logic           cfg_done;
	logic           mode_fall_through_mode;
	logic           fifo_in_ready;
	logic           fifo_out_valid;
	logic [DW-1:0]  fifo_out_data;
	logic [CW-1:0]  fifo_count;
	logic           wr_go;
	logic           pop;
	logic           std_read;
	logic           fall_through_mode_read;
	logic           fall_load;
	logic           ofs_wr;
	logic           ofs_rd;
	logic [OW-1:0]  ofs_rd_data;
	logic [OW-1:0]  empty_threshold;
	logic [OW-1:0]  full_threshold;
	logic [DW-1:0]  data_q;
	logic           or_valid;
	logic [1:0]     fall_wait;
	logic           fifo_full;

	function automatic logic words_at_most(input logic [CW-1:0] words, input logic [OW-1:0] lim);
		return {{(OW + 1 - CW){1'b0}}, words} <= {1'b0, lim};
	endfunction : words_at_most

	function automatic logic words_reach(input logic [CW-1:0] words, input logic [OW-1:0] off);
		return ({{(OW + 1 - CW){1'b0}}, words} + {1'b0, off}) >= (OW + 1)'(DEPTH);
	endfunction : words_reach

	// mode latched at release
	// The pins decode directly while reset holds so the empty pin shows the right level
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			mode_q   <= mode_standard;
			cfg_done <= 1'b0;
		end else if (!cfg_done) begin
			mode_q   <= decode_mode(read_expansion_in_n, write_expansion_in_n);
			cfg_done <= 1'b1;
		end
	end

	assign timing_mode = cfg_done ? mode_q : decode_mode(read_expansion_in_n, write_expansion_in_n);
	assign mode_fall_through_mode   = (timing_mode == mode_fall_through);
	assign fifo_full   = (fifo_count == CW'(DEPTH));

	assign wr_go = load_offset_n && !write_en_n && fifo_in_ready;

	assign ofs_wr = !load_offset_n && !write_en_n;

	assign ofs_rd = !load_offset_n && !read_en_n && !mode_fall_through_mode;

	assign std_read  = !mode_fall_through_mode && load_offset_n && !read_en_n && fifo_out_valid;
	assign fall_through_mode_read = mode_fall_through_mode && load_offset_n && !read_en_n && or_valid && fifo_out_valid;
	assign fall_load = mode_fall_through_mode && !or_valid && fifo_out_valid && (fall_wait == 2'(`FALL_THROUGH_EDGES - 1));
	assign pop       = std_read || fall_through_mode_read || fall_load;

	word_fifo #(
		.WIDTH(DW),
		.DEPTH(DEPTH),
		.CW   (CW)
	) u_store (
		.clock    (clock),
		.rst_n    (rst_n),
		.in_valid (load_offset_n && !write_en_n),
		.in_ready (fifo_in_ready),
		.in_data  (data_in),
		.out_valid(fifo_out_valid),
		.out_ready(pop),
		.out_data (fifo_out_data),
		.count    (fifo_count)
	);

	offset_bank #(
		.OW(OW)
	) u_offsets (
		.clock          (clock),
		.rst_n          (rst_n),
		.wr_en          (ofs_wr),
		.wr_data        (data_in[`OFFSET_FIELD_MSB:`OFFSET_FIELD_LSB]),
		.rd_en          (ofs_rd),
		.rd_data        (ofs_rd_data),
		.empty_threshold(empty_threshold),
		.full_threshold (full_threshold)
	);

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			fall_wait <= 2'h0;
		end else if (!mode_fall_through_mode || or_valid || !fifo_out_valid || fall_load) begin
			fall_wait <= 2'h0;
		end else begin
			fall_wait <= 2'(fall_wait + 1'b1);
		end
	end

	// true read on empty clears or_valid and raises output-ready
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			or_valid <= 1'b0;
		end else if (fall_load) begin
			or_valid <= 1'b1;
		end else if (mode_fall_through_mode && or_valid && load_offset_n && !read_en_n && !fifo_out_valid) begin
			or_valid <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			data_q <= `DATA_OUT_RESET;
		end else if (pop) begin
			data_q <= fifo_out_data;
		end else if (ofs_rd) begin
			data_q <= DW'(ofs_rd_data);
		end
	end

	assign data_out    = data_q;
	assign data_out_oe = !output_en_n;

	// all inputs to the flags are flops, except the mode pins that the empty pin decodes while reset holds
	always_comb begin
		if (!cfg_done) begin
			full_flag_n = 1'b1;
		end else if (mode_fall_through_mode) begin
			full_flag_n = fifo_full && or_valid;
		end else begin
			full_flag_n = !fifo_full;
		end
	end

	// empty pin reset level by mode
	assign empty_flag_n = mode_fall_through_mode ? !or_valid : (fifo_count != '0);

	// Partial flags use memory occupancy only; they are not buffered further
	assign half_full_n    = !cfg_done || (fifo_count <= CW'(DEPTH / 2));
	assign almost_full_n  = !cfg_done || !words_reach(fifo_count, full_threshold);
	assign almost_empty_n = cfg_done && !words_at_most(fifo_count, empty_threshold);

	default clocking cb @(posedge clock);
	endclocking

	default disable iff (!rst_n);

	chk_reset_state: assert property (disable iff (1'b0)
		!rst_n |-> (fifo_count == '0) && (data_q == '0) && !or_valid)
		else $error("reset left pointers or output register set");

	chk_reset_flags: assert property (disable iff (1'b0)
		!rst_n |-> full_flag_n && half_full_n && almost_full_n && !almost_empty_n)
		else $error("flag levels wrong during reset");

	chk_reset_empty: assert property (disable iff (1'b0)
		!rst_n |-> empty_flag_n == (decode_mode(read_expansion_in_n, write_expansion_in_n)
			== mode_fall_through))
		else $error("empty pin level wrong during reset");

	chk_write_store: assert property (
		wr_go && !pop |=> fifo_count == $past(fifo_count) + 1'b1)
		else $error("accepted write did not add a word");

	chk_write_blocked: assert property (
		(write_en_n || fifo_full || !load_offset_n) && !pop |=> $stable(fifo_count))
		else $error("idle or full write changed occupancy");

	chk_full_flag: assert property (
		cfg_done && !mode_fall_through_mode |-> full_flag_n == (fifo_count != CW'(DEPTH)))
		else $error("standard full flag disagrees with occupancy");

	chk_read_hold: assert property (
		read_en_n && !fall_load |=> $stable(data_q))
		else $error("output register changed without a read");

	chk_read_load: assert property (
		std_read |=> data_q == $past(fifo_out_data))
		else $error("read did not load the next word");

	chk_fall_latency: assert property (
		mode_fall_through_mode && cfg_done && !or_valid && fifo_count == '0 && wr_go && load_offset_n
			|-> ##3 !or_valid ##1 or_valid)
		else $error("first word did not fall through on the third edge");

	chk_output_ready: assert property (
		mode_fall_through_mode && or_valid && load_offset_n && !read_en_n && !fifo_out_valid
			|=> empty_flag_n && $stable(data_q))
		else $error("output-ready did not rise after last word read");

	chk_no_ofs_read: assert property (
		mode_fall_through_mode |-> !ofs_rd)
		else $error("threshold readout in fall-through mode");

	cov_fill_full: cover property (fifo_full && !write_en_n && load_offset_n);
	cov_fall_through: cover property (fall_load);
	cov_offset_read: cover property (ofs_rd ##1 ofs_rd);
	cov_read_empty: cover property (!mode_fall_through_mode && !read_en_n && !fifo_out_valid);

endmodule : fifo_ctl

`default_nettype wire

// ==== far_side.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_consts.svh"

// Writing and reading logic that faces the buffer; one request set per edge
module far_side (
	input  wire logic                        clock,
	input  wire logic                        rst_n,
	output var logic [`FIFO_DATA_WIDTH-1:0] data_in,
	output var logic                         write_en_n,
	output var logic                         read_en_n,
	output var logic                         load_offset_n,
	output var logic                         output_en_n
);
	initial begin
		{write_en_n, read_en_n, load_offset_n, output_en_n} = 4'hF;
		data_in = 18'h00000;
	end

	// Drive just after an edge and hold until the next edge takes it
	task automatic cyc(input logic w, input logic r, input logic ld, input logic oe,
		input logic [`FIFO_DATA_WIDTH-1:0] d);
		write_en_n <= w | !rst_n;
		// threshold read never with threshold write
		read_en_n <= r | (!ld & !w);
		load_offset_n <= ld;
		output_en_n <= oe;
		data_in <= d;
		@(posedge clock);
	endtask : cyc
endmodule : far_side
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_consts.svh"

module tb_top;
	import fifo_ctl_pkg::*;
	localparam int DEPTH = `FIFO_DEPTH;
	logic         clock, rst_n, first_load_n, rxi_n, wxi_n;
	logic [17:0]  data_in, data_out, exp_q;
	logic         write_en_n, read_en_n, load_offset_n, output_en_n, data_out_oe;
	logic         full_flag_n, empty_flag_n, half_full_n, almost_full_n, almost_empty_n;
	timing_mode_e timing_mode;
	logic         exp_e, exp_f, chk_on, fall_through_mode, wsel, rsel;
	logic [11:0]  e_thr, f_thr;
	logic [17:0]  mem[$];
	int           n_mismatch, comparisons;

	fifo_ctl #(.DW(18), .DEPTH(DEPTH)) i_dut (.clock(clock), .rst_n(rst_n),
		.data_in(data_in), .write_en_n(write_en_n), .read_en_n(read_en_n),
		.load_offset_n(load_offset_n), .output_en_n(output_en_n),
		.first_load_n(first_load_n), .read_expansion_in_n(rxi_n),
		.write_expansion_in_n(wxi_n), .data_out(data_out), .data_out_oe(data_out_oe),
		.full_flag_n(full_flag_n), .empty_flag_n(empty_flag_n), .half_full_n(half_full_n),
		.almost_full_n(almost_full_n), .almost_empty_n(almost_empty_n),
		.timing_mode(timing_mode));
	far_side i_far (.clock(clock), .rst_n(rst_n), .data_in(data_in),
		.write_en_n(write_en_n), .read_en_n(read_en_n), .load_offset_n(load_offset_n),
		.output_en_n(output_en_n));

	initial begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	task automatic report_and_stop;
		$display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop

	// Standard-mode expectation for one taken edge; occupancy is sampled before the edge
	function automatic void expect_std(input logic w, input logic r, input logic ld,
		input logic [17:0] d);
		int n;
		n = mem.size();
		if (!ld) begin
			if (!w) begin
				if (wsel) f_thr = d[11:0];
				else e_thr = d[11:0];
				wsel = !wsel;
			end else if (!r) begin
				exp_q = {6'h00, rsel ? f_thr : e_thr};
				rsel = !rsel;
			end
		end else begin
			if (!r && n > 0) exp_q = mem.pop_front();
			if (!w && n < DEPTH) mem.push_back(d);
		end
		exp_e = mem.size() > 0;
		exp_f = mem.size() != DEPTH;
	endfunction : expect_std

	task automatic go(input logic w, input logic r, input logic ld, input logic oe,
		input logic [17:0] d);
		i_far.cyc(w, r, ld, oe, d);
		if (!fall_through_mode) expect_std(w, r | (!ld & !w), ld, d);
	endtask : go

	always @(negedge clock) begin
		if (chk_on) begin
			check("empty_flag_n", empty_flag_n, exp_e);
			check("full_flag_n", full_flag_n, exp_f);
			check("data_out", data_out, exp_q);
			check("data_out_oe", data_out_oe, !output_en_n);
			check("timing_mode", timing_mode, fall_through_mode ? mode_fall_through : mode_standard);
		end
		// Partial flags follow memory occupancy: half-full against half the depth, the almost flags against the programmed thresholds
		if (chk_on && !fall_through_mode) begin
			check("half_full_n", half_full_n, mem.size() <= DEPTH / 2);
			check("almost_full_n", almost_full_n, !(mem.size() + f_thr >= DEPTH));
			check("almost_empty_n", almost_empty_n, !(mem.size() <= e_thr));
		end
	end

	task automatic do_reset(input logic ft);
		go(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
		chk_on = 1'b0;
		fall_through_mode = ft;
		rst_n <= 1'b0;
		rxi_n <= !ft;
		wxi_n <= 1'b1;
		mem.delete();
		{wsel, rsel} = 2'h0;
		e_thr = 12'h01F;
		f_thr = 12'h01F;
		exp_q = 18'h00000;
		repeat (10) @(posedge clock);
		check("rst data_out", data_out, 18'h00000);
		check("rst full", full_flag_n, 1'b1);
		check("rst half", half_full_n, 1'b1);
		check("rst almost_full", almost_full_n, 1'b1);
		check("rst almost_empty", almost_empty_n, 1'b0);
		check("rst empty", empty_flag_n, ft);
		rst_n <= 1'b1;
		@(posedge clock);
		exp_e = ft;
		exp_f = !ft;
		chk_on = 1'b1;
	endtask : do_reset

	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		report_and_stop();
	end

	initial begin
		{rst_n, first_load_n, rxi_n, wxi_n} = 4'h7;
		{chk_on, fall_through_mode} = 2'h0;
		n_mismatch = 0;
		comparisons = 0;
		void'($urandom(32'h6C1E1DBC));
		do_reset(1'b0);
		// default thresholds read back, own read pointer
		repeat (2) go(1'b1, 1'b0, 1'b0, 1'b0, 18'h00000);
		// empty, full, empty again; idle load edge
		go(1'b0, 1'b1, 1'b0, 1'b0, 18'h00003);
		go(1'b1, 1'b1, 1'b0, 1'b0, 18'h00009);
		go(1'b0, 1'b1, 1'b0, 1'b0, 18'h3F005);
		go(1'b0, 1'b1, 1'b0, 1'b0, 18'h00002);
		go(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
		go(1'b0, 1'b1, 1'b0, 1'b0, 18'h00006);
		repeat (3) go(1'b1, 1'b0, 1'b0, 1'b0, 18'h00000);
		// overfill, overdrain, hold with released pins
		repeat (DEPTH + 2) go(1'b0, 1'b1, 1'b1, 1'b0, 18'($urandom));
		repeat (DEPTH + 2) go(1'b1, 1'b0, 1'b1, 1'b0, 18'h00000);
		repeat (3) go(1'b1, 1'b1, 1'b1, 1'b1, 18'h3FFFF);
		// writes and reads mixed, bias swaps to sweep full and empty
		for (int k = 0; k < 600; k++)
			go(($urandom % 4) >= (((k / 60) % 2) ? 1 : 3), ($urandom % 4) >= (((k / 60) % 2) ? 3 : 1),
				($urandom % 16) != 0, ($urandom % 8) == 0, 18'($urandom));
		// Second reset in mid-run selects fall-through
		do_reset(1'b1);
		// first word shows alone on the third edge
		go(1'b0, 1'b1, 1'b1, 1'b0, 18'h2AAAA);
		repeat (2) go(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
		go(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
		exp_q = 18'h2AAAA;
		exp_e = 1'b0;
		go(1'b1, 1'b0, 1'b0, 1'b0, 18'h00000);
		for (int i = 0; i < DEPTH; i++) begin
			go(1'b0, 1'b1, 1'b1, 1'b0, 18'h00010 + 18'(i));
			exp_f = (i == DEPTH - 1);
		end
		go(1'b0, 1'b1, 1'b1, 1'b0, 18'h3FFFF);
		for (int i = 0; i < DEPTH; i++) begin
			go(1'b1, 1'b0, 1'b1, 1'b0, 18'h00000);
			exp_q = 18'h00010 + 18'(i);
			exp_f = 1'b0;
		end
		// true read past the last word raises output-ready, data kept
		go(1'b1, 1'b0, 1'b1, 1'b0, 18'h00000);
		exp_e = 1'b1;
		go(1'b1, 1'b0, 1'b1, 1'b0, 18'h00000);
		go(1'b1, 1'b1, 1'b1, 1'b0, 18'h00000);
		report_and_stop();
	end
endmodule : tb_top
`default_nettype wire
